// *** hdl/rpd_pkg.sv ***
package rpd_pkg;
    // sample pacing
    localparam int unsigned CLK_HZ        = 50000000;
    localparam int unsigned SAMPLE_HZ     = 900000;
    localparam int unsigned SAMPLE_DIV    = CLK_HZ / SAMPLE_HZ;
    localparam logic [5:0]  SAMPLE_DIV_M1 = 6'(SAMPLE_DIV - 1);
    localparam int unsigned BANDWIDTH_HZ  = 14000;
    // datapath widths
    localparam int unsigned SMP_W  = 16;
    localparam int unsigned CUR_W  = 20;
    localparam int unsigned PROD_W = 36;
    localparam int unsigned FRAC_W = 12;
    localparam int unsigned LPF_W  = PROD_W + FRAC_W;
    localparam int unsigned ACC_W  = 52;
    // filter shifts
    localparam int unsigned HPF_SHIFT = 10;
    localparam int unsigned PHC_SHIFT = 6;
    localparam int unsigned LPF_SHIFT = 14;
    // gain select codes
    localparam logic [1:0] GAIN_X1  = 2'h0;
    localparam logic [1:0] GAIN_X2  = 2'h1;
    localparam logic [1:0] GAIN_X8  = 2'h2;
    localparam logic [1:0] GAIN_X16 = 2'h3;
    // pulse thresholds, low rate is 2048 times the calibration one
    localparam logic [ACC_W-1:0] CAL_THRESH = 52'h100_0000_0000;
    localparam logic [ACC_W-1:0] LOW_THRESH = 52'h8_0000_0000_0000;
    // reset values
    localparam logic [5:0] DIV_RESET = 6'h00;
endpackage : rpd_pkg

// *** hdl/rpd_pulse_accum.sv ***
module rpd_pulse_accum #(
    parameter logic [rpd_pkg::ACC_W-1:0] THRESH = rpd_pkg::CAL_THRESH
) (
    // clock and reset
    input  wire logic                       mclk_i,
    input  wire logic                       reset_n_i,
    // magnitude stream
    input  wire logic                       tick_i,
    input  wire logic [rpd_pkg::PROD_W-1:0] mag_i,
    // overflow event
    output logic                            hit_o
);
    import rpd_pkg::*;

    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic             hit;
    } rpd_acc_t;

    rpd_acc_t st_reg;
    rpd_acc_t st_next;

    always_comb begin
        logic [ACC_W-1:0] sum;
        sum     = '0;
        st_next = st_reg;
        st_next.hit = 1'b0;
        if (tick_i) begin
            sum = st_reg.acc + {{(ACC_W-PROD_W){1'b0}}, mag_i};   // see RL6 see RL7
            if (sum >= THRESH) begin
                st_next.acc = sum - THRESH;
                st_next.hit = 1'b1;
            end else begin
                st_next.acc = sum;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_reg <= '0;                                          // see RL12
        end else begin
            st_reg <= st_next;
        end
    end

    assign hit_o = st_reg.hit;

    a_accum_wraps: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RL6
        st_reg.hit |-> st_reg.acc < THRESH)
        else $error("accumulator not below threshold after pulse");

endmodule : rpd_pulse_accum

// *** hdl/rpd_datapath.sv ***
// Behaviour
// RL1: gain select 00,01,10,11 scales current samples by 1,2,8,16.
// RL2: both 16-bit channels are sampled at a 900 kHz rate.
// RL3: high-pass filter removes dc from current samples before multiplying.
// RL4: instantaneous power is current sample times matching voltage sample.
// RL5: low-pass filter of instantaneous power yields dc real power.
// RL6: low-rate pulses come from long accumulation of filtered real power.
// RL7: calibration pulses use a much shorter accumulation, higher rate.
// RL8: path passes content up to 14 kHz bandwidth.
// RL9: high-pass filter active while enable high, bypassed while low.
// RL10: phase compensation active only while high-pass filter enabled.
// RL11: negative flag follows power sign, changes only with calibration pulse.
// RL12: all datapath state cleared in reset, advances on master clock only.
module rpd_datapath (
    // clock and reset
    input  wire logic                       mclk_i,
    input  wire logic                       reset_n_i,
    // control pins
    input  wire logic                       gain_select_hi_i,
    input  wire logic                       gain_select_lo_i,
    input  wire logic                       highpass_enable_i,
    // converter samples
    input  wire logic [rpd_pkg::SMP_W-1:0]  current_sample_i,
    input  wire logic [rpd_pkg::SMP_W-1:0]  voltage_sample_i,
    output logic                            sample_strobe_o,
    // pulse outputs
    output logic                            calibration_pulse_out_o,
    output logic                            low_rate_pulse_out_a_o,
    output logic                            low_rate_pulse_out_b_o,
    output logic                            negative_power_flag_o
);
    import rpd_pkg::*;

    typedef struct packed {
        logic [5:0]               div;
        logic                     tick;
        logic signed [CUR_W-1:0]  cur_g;
        logic signed [31:0]       dc;
        logic signed [CUR_W-1:0]  hp;
        logic signed [CUR_W-1:0]  hp_prev;
        logic signed [CUR_W-1:0]  comp;
        logic signed [SMP_W-1:0]  volt_d1;
        logic signed [SMP_W-1:0]  volt_d2;
        logic signed [SMP_W-1:0]  volt_d3;
        logic signed [PROD_W-1:0] prod;
        logic signed [LPF_W-1:0]  lpf;
        logic                     cal;
        logic                     low_a;
        logic                     low_b;
        logic                     low_sel;
        logic                     neg;
    } rpd_state_t;

    rpd_state_t st_reg;
    rpd_state_t st_next;

    logic [1:0]               gain_sel;
    logic signed [CUR_W-1:0]  cur_ext;
    logic signed [CUR_W-1:0]  cur_gain;
    logic signed [PROD_W-1:0] lpf_int;
    logic [PROD_W-1:0]        lpf_mag;
    logic signed [LPF_W-1:0]  lpf_step;
    logic                     cal_hit;
    logic                     low_hit;

    assign gain_sel = {gain_select_hi_i, gain_select_lo_i};
    assign cur_ext  = {{(CUR_W-SMP_W){current_sample_i[SMP_W-1]}}, current_sample_i};
    assign lpf_int  = st_reg.lpf[LPF_W-1:FRAC_W];
    assign lpf_mag  = lpf_int[PROD_W-1] ? PROD_W'(-lpf_int) : lpf_int;
    // signed difference, so a falling power level steps the filter down
    assign lpf_step = ($signed({st_reg.prod, {FRAC_W{1'b0}}}) - st_reg.lpf) >>> LPF_SHIFT;

    always_comb begin
        case (gain_sel)                                            // see RL1
            GAIN_X1:  cur_gain = cur_ext;
            GAIN_X2:  cur_gain = cur_ext <<< 1;
            GAIN_X8:  cur_gain = cur_ext <<< 3;
            GAIN_X16: cur_gain = cur_ext <<< 4;
            default:  cur_gain = cur_ext;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic signed [31:0]      dc_err;
        logic signed [CUR_W:0]   slope;
        logic signed [CUR_W:0]   lagged;
        dc_err  = '0;
        slope   = '0;
        lagged  = '0;
        st_next = st_reg;
        st_next.cal   = cal_hit;
        st_next.low_a = 1'b0;
        st_next.low_b = 1'b0;
        // sample pacing, 900 kHz also covers the 14 kHz band
        st_next.tick = (st_reg.div == SAMPLE_DIV_M1);              // see RL2 see RL8
        st_next.div  = st_next.tick ? DIV_RESET : st_reg.div + 6'h01;
        if (st_reg.tick) begin
            st_next.cur_g   = cur_gain;
            st_next.volt_d1 = voltage_sample_i;
            st_next.volt_d2 = st_reg.volt_d1;
            st_next.volt_d3 = st_reg.volt_d2;
            dc_err = {st_reg.cur_g, 12'h000} - st_reg.dc;
            if (highpass_enable_i) begin                           // see RL9
                st_next.dc = st_reg.dc + (dc_err >>> HPF_SHIFT);
                st_next.hp = st_reg.cur_g - CUR_W'(st_reg.dc >>> FRAC_W); // see RL3
            end else begin
                st_next.dc = '0;
                st_next.hp = st_reg.cur_g;
            end
            st_next.hp_prev = st_reg.hp;
            slope  = {st_reg.hp[CUR_W-1], st_reg.hp} - {st_reg.hp_prev[CUR_W-1], st_reg.hp_prev};
            lagged = {st_reg.hp[CUR_W-1], st_reg.hp} - (slope >>> PHC_SHIFT);
            // lag offsets the filter lead, only while it is in circuit
            st_next.comp = highpass_enable_i ? lagged[CUR_W-1:0] : st_reg.hp; // see RL10
            st_next.prod = PROD_W'(st_reg.comp * st_reg.volt_d3); // see RL4
            st_next.lpf  = st_reg.lpf + lpf_step;                  // see RL5
        end
        // alternate low-rate events across the two outputs
        if (low_hit) begin                                         // see RL6
            st_next.low_a   = ~st_reg.low_sel;
            st_next.low_b   = st_reg.low_sel;
            st_next.low_sel = ~st_reg.low_sel;
        end
        if (cal_hit) begin
            st_next.neg = lpf_int[PROD_W-1];                       // see RL11
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_reg <= '0;                                          // see RL12
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    rpd_pulse_accum #(
        .THRESH (CAL_THRESH)
    ) u_cal_accum (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .tick_i    (st_reg.tick),
        .mag_i     (lpf_mag),
        .hit_o     (cal_hit)
    );                                                             // see RL7

    rpd_pulse_accum #(
        .THRESH (LOW_THRESH)
    ) u_low_accum (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .tick_i    (st_reg.tick),
        .mag_i     (lpf_mag),
        .hit_o     (low_hit)
    );                                                             // see RL6

    assign sample_strobe_o         = st_reg.tick;
    assign calibration_pulse_out_o = st_reg.cal;
    assign low_rate_pulse_out_a_o  = st_reg.low_a;
    assign low_rate_pulse_out_b_o  = st_reg.low_b;
    assign negative_power_flag_o   = st_reg.neg;

    ////////////////////////////////////////////////////////////////////////////
    sequence s_tick;
        st_reg.tick;
    endsequence

    sequence s_next_tick;
        (!st_reg.tick)[*8] ##47 st_reg.tick;
    endsequence

    a_sample_pace: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RL2 see RL8
        s_tick |=> s_next_tick)
        else $error("sample tick spacing is not 55 clocks");

    a_gain_decode: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RL1
        st_reg.tick && gain_sel == GAIN_X8 |=> st_reg.cur_g == ($past(cur_ext) <<< 3))
        else $error("gain 8 not applied");

    a_hpf_removes: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RL3
        st_reg.tick && highpass_enable_i
        |=> st_reg.hp == $past(st_reg.cur_g) - CUR_W'($past(st_reg.dc) >>> FRAC_W))
        else $error("high-pass output wrong");

    a_hpf_bypass: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RL9
        st_reg.tick && !highpass_enable_i |=> st_reg.hp == $past(st_reg.cur_g) && st_reg.dc == 0)
        else $error("high-pass not bypassed");

    a_phase_off: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RL10
        st_reg.tick && !highpass_enable_i |=> st_reg.comp == $past(st_reg.hp))
        else $error("phase compensation active while bypassed");

    a_power_product: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RL4
        st_reg.tick |=> st_reg.prod == PROD_W'($past(st_reg.comp) * $past(st_reg.volt_d3)))
        else $error("power product wrong");

    a_lpf_track: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RL5
        st_reg.tick |=> st_reg.lpf == $past(st_reg.lpf) + $past(lpf_step))
        else $error("low-pass step wrong");

    a_neg_on_cal: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RL11
        $changed(negative_power_flag_o) |-> calibration_pulse_out_o)
        else $error("negative flag moved without calibration pulse");

    a_low_alternate: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RL6
        low_hit |=> low_rate_pulse_out_a_o != low_rate_pulse_out_b_o)
        else $error("low-rate event not on exactly one output");

    a_reset_clear: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RL12
        $rose(reset_n_i) |-> st_reg.lpf == 0 && st_reg.prod == 0 && st_reg.dc == 0)
        else $error("datapath state not cleared by reset");

    a_cal_follow: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RL7
        cal_hit |=> calibration_pulse_out_o)
        else $error("calibration pulse did not follow accumulator hit");

    a_cal_single: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RL7
        calibration_pulse_out_o |=> !calibration_pulse_out_o)
        else $error("calibration pulse longer than one clock");

    a_neg_sign: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see RL11
        calibration_pulse_out_o |-> negative_power_flag_o == $past(lpf_int[PROD_W-1]))
        else $error("negative flag does not match filtered power sign");

endmodule : rpd_datapath

// *** tb/rpd_conv_model.sv ***
module rpd_conv_model import rpd_pkg::*; (
    // clock and sample strobe
    input  wire logic                      mclk_i,
    input  wire logic                      strobe_i,
    // levels the converters digitise
    input  wire logic [rpd_pkg::SMP_W-1:0] cur_level_i,
    input  wire logic [rpd_pkg::SMP_W-1:0] volt_level_i,
    // converter words
    output logic      [rpd_pkg::SMP_W-1:0] current_sample_o,
    output logic      [rpd_pkg::SMP_W-1:0] voltage_sample_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        current_sample_o = '0;
        voltage_sample_o = '0;
    end

    ////////////////////////////////////////////////////////////////
    // word valid only in strobe cycle, inverted junk elsewhere
    always @(negedge mclk_i) begin
        current_sample_o <= strobe_i ? cur_level_i : ~cur_level_i;
        voltage_sample_o <= strobe_i ? volt_level_i : ~volt_level_i;
    end
endmodule : rpd_conv_model

// *** tb/real_power_datapath_bench.sv ***
module real_power_datapath_bench import rpd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic [1:0]       gain;
        int               factor;
        logic [SMP_W-1:0] cur;
        logic [SMP_W-1:0] volt;
    } rpd_row_t;

    logic                mclk_i    = 1'b0;
    logic                reset_n_i = 1'b0;
    logic                g_hi      = 1'b0;
    logic                g_lo      = 1'b0;
    logic                hp_en     = 1'b0;
    logic [SMP_W-1:0]    cur_lvl   = '0;
    logic [SMP_W-1:0]    volt_lvl  = '0;
    logic [SMP_W-1:0]    cur_s;
    logic [SMP_W-1:0]    volt_s;
    logic                strobe, cal, low_a, low_b, negf;
    logic                negf_q    = 1'b0;
    int                  fails     = 0;
    int                  n_tests   = 0;
    int                  n_cal     = 0;
    int                  n_low     = 0;
    int                  k;
    longint              exp_cur;
    longint              exp_pow;
    // gain code, factor it stands for, current level, voltage level
    rpd_row_t            rows [6]  = '{'{2'h0, 1, 16'h1234, 16'h0100},
                                       '{2'h1, 2, 16'hF000, 16'h0123},
                                       '{2'h2, 8, 16'h0ABC, 16'hFF00},
                                       '{2'h3, 16, 16'h8001, 16'h8001},
                                       '{2'h3, 16, 16'h7FFF, 16'h7FFF},
                                       '{2'h0, 1, 16'h0000, 16'h7FFF}};

    always #10 mclk_i = ~mclk_i;

    rpd_datapath DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .gain_select_hi_i(g_hi),
        .gain_select_lo_i(g_lo), .highpass_enable_i(hp_en), .current_sample_i(cur_s),
        .voltage_sample_i(volt_s), .sample_strobe_o(strobe), .calibration_pulse_out_o(cal),
        .low_rate_pulse_out_a_o(low_a), .low_rate_pulse_out_b_o(low_b),
        .negative_power_flag_o(negf));
    rpd_conv_model conv (.mclk_i(mclk_i), .strobe_i(strobe), .cur_level_i(cur_lvl),
        .volt_level_i(volt_lvl), .current_sample_o(cur_s), .voltage_sample_o(volt_s));

    ////////////////////////////////////////////////////////////////
    task check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task report_and_stop;
        $display("comparisons=%0d mismatches=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    // bounded wait for a number of sample strobes, seen at falling edges
    task wait_strobes(input int want);
        int got;
        int lim;
        got = 0;
        lim = 0;
        while (got < want && lim < want * 60) begin
            @(negedge mclk_i);
            lim++;
            if (strobe === 1'b1) got++;
        end
        check(got, want);
    endtask : wait_strobes

    // pulse counting and flag watch, outputs settled at the falling edge
    always @(negedge mclk_i) begin
        if (cal === 1'b1) n_cal++;
        if (low_a === 1'b1 || low_b === 1'b1) n_low++;
        if (negf !== negf_q && cal !== 1'b1) check(negf, negf_q);
        negf_q = negf;
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge mclk_i);
        reset_n_i = 1'b1;
        // filter bypassed, so the product is gained current times voltage
        foreach (rows[i]) begin
            @(negedge mclk_i);
            {g_hi, g_lo} = rows[i].gain;
            cur_lvl      = rows[i].cur;
            volt_lvl     = rows[i].volt;
            exp_cur      = longint'($signed(rows[i].cur)) * rows[i].factor;
            exp_pow      = exp_cur * longint'($signed(rows[i].volt));
            wait_strobes(5);
            check(64'($signed(DUT.st_reg.cur_g)), exp_cur);
            check(64'($signed(DUT.st_reg.prod)), exp_pow);
            $display("row %0d done", i);
        end
        // dc current with the filter in: its output starts to fall below the input
        @(negedge mclk_i);
        {g_hi, g_lo} = 2'h0;
        hp_en        = 1'b1;
        cur_lvl      = 16'h4000;
        volt_lvl     = 16'h0100;
        wait_strobes(5);
        check(DUT.st_reg.hp > 0 && DUT.st_reg.hp < 20'sh04000, 1'b1);
        hp_en = 1'b0;
        wait_strobes(2);
        check(64'($signed(DUT.st_reg.hp)), 64'h4000);
        $display("high-pass test done");
        // reset in mid-run clears outputs and datapath state
        @(negedge mclk_i);
        reset_n_i = 1'b0;
        n_cal     = 0;
        n_low     = 0;
        repeat (8) @(negedge mclk_i);
        check({strobe, cal, low_a, low_b, negf}, 5'h00);
        check(64'(DUT.st_reg.prod), 64'h0);
        $display("reset test done");
        {g_hi, g_lo} = 2'h3;
        cur_lvl = 16'h7FFF;
        volt_lvl = 16'h8001;
        reset_n_i = 1'b1;
        k = 0;
        while (strobe !== 1'b1 && k < 60) begin
            @(negedge mclk_i);
            k++;
        end
        check(k, 55);
        k = 0;
        do begin
            @(negedge mclk_i);
            k++;
        end while (strobe !== 1'b1 && k < 60);
        check(k, 55);
        $display("strobe test done");
        k = 0;
        while (n_cal == 0 && k < 95000) begin
            @(negedge mclk_i);
            k++;
        end
        check(n_cal > 0, 1'b1);
        check(negf, 1'b1);
        check(n_low, 0);
        $display("power test done");
        report_and_stop();
    end
endmodule : real_power_datapath_bench
